// *** center_pwm_pkg.sv ***
// Constants, register map and carrier types of the center-aligned PWM timer
package center_pwm_pkg;
   localparam int NUM_CH = 2;

   // Register byte addresses, one register per aligned word
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CNT_HI = 8'h04;
   localparam logic [7:0] ADDR_CNT_LO = 8'h08;
   localparam logic [7:0] ADDR_MOD_HI = 8'h0C;
   localparam logic [7:0] ADDR_MOD_LO = 8'h10;
   localparam logic [7:0] ADDR_CH_BASE = 8'h14;
   localparam logic [7:0] ADDR_CH_STRIDE = 8'h0C;
   localparam logic [7:0] OFS_CH_CTRL = 8'h00;
   localparam logic [7:0] OFS_CH_VAL_HI = 8'h04;
   localparam logic [7:0] OFS_CH_VAL_LO = 8'h08;
   localparam logic [23:0] ADDR_UPPER_ZERO = 24'h000000;

   // Timer control register fields
   localparam int CTRL_OVF_FLAG = 7;
   localparam int CTRL_OVF_IE = 6;
   localparam int CTRL_CENTER_ALIGNED_PWM = 5;
   localparam int CTRL_CLKS_LSB = 3;
   localparam int CTRL_PS_LSB = 0;

   // Channel control register fields
   localparam int CH_FLAG = 7;
   localparam int CH_IE = 6;
   localparam int CH_MODE_LSB = 4;
   localparam int CH_ELS_LSB = 2;

   localparam logic [1:0] CLKS_OFF = 2'h0;
   localparam logic [1:0] CLKS_SYS = 2'h1;
   localparam logic [1:0] MODE_OC = 2'h1;
   localparam logic [1:0] ELS_NONE = 2'h0;
   localparam logic [1:0] ELS_TOGGLE = 2'h1;
   localparam logic [1:0] ELS_CLEAR = 2'h2;
   localparam logic [1:0] ELS_SET = 2'h3;

   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam int SIGN_BIT = 15;
   localparam logic [6:0] PRESC_ZERO = 7'h00;
   localparam logic [6:0] PRESC_ONES = 7'h7F;
   localparam logic [6:0] PRESC_ONE = 7'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h00000000;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [1:0] {
      DIR_UP = 2'b01,
      DIR_DOWN = 2'b10
   } dir_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
      logic [31:0] hwdata;
   } ahb_in_t;

   typedef struct packed {
      logic flag;
      logic ie;
      logic [1:0] mode;
      logic [1:0] els;
   } ch_cfg_t;
endpackage

// *** center_pwm_timer.sv ***
// 16-bit timer with center-aligned PWM channels behind an AHB-Lite slave
// Notes on behaviour
// - Center-align select makes counter run 0 up to modulo, back down, forever.
// - Center-aligned pulse is twice channel value, period twice modulo value.
// - Channel flag sets on matches both counting down and counting up.
// - Channel interrupt request is flag AND channel interrupt enable.
// - Edge/level 0:0 still sets flag but leaves output undriven.
// - Edge/level 1:0: high on down-count match, low on up-count match.
// - Edge/level X:1: low on down-count match, high on up-count match.
// - Channel value zero or negative gives 0% duty and no flag.
// - Positive channel value at or above nonzero modulo gives 100%, no flag.
// - Clock source off: modulo and channel values load on second byte write.
// - Clock on, not centered: modulo loads at wrap to zero, or 0xFFFF wrap.
// - Clock on, centered: modulo and channel load at step from modulo down.
// - Output compare: channel value loads on next counter change after write.
// - Edge-aligned PWM: channel value loads at wrap to zero.
// - Debug halt freezes counter and all channel outputs.
// - Counter byte write clears counter, resets non-compare outputs, even halted.
// - Chip reset returns the whole timer to its reset state.
// - Overflow interrupt request is overflow flag AND overflow enable.
// - Up-down counting sets overflow flag stepping from modulo to modulo minus one.
// - Counter byte write clears counter and resets non-compare channel outputs.
`timescale 1ns/1ps
module center_pwm_timer (
   input wire logic sys_clk, // System clock, 125 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire center_pwm_pkg::ahb_in_t bus_in, // AHB-Lite request signals
   output logic hreadyout, // Slave ready, never stretched
   output logic hresp, // Always OKAY
   output logic [31:0] hrdata, // Read data, registered
   input wire logic ext_clk_tick, // Synchronous external clock pulse
   input wire logic debug_halt_mode, // Debug halt active
   output logic [center_pwm_pkg::NUM_CH-1:0] ch_out, // Channel pin levels
   output logic [center_pwm_pkg::NUM_CH-1:0] ch_oe, // Channel pin enables
   output logic overflow_irq, // Overflow interrupt request
   output logic [center_pwm_pkg::NUM_CH-1:0] channel_irq // Channel requests
);
   import center_pwm_pkg::*;

   logic dph_valid_reg;
   logic dph_write_reg;
   logic [7:0] dph_addr_reg;
   logic addr_ok;
   logic [7:0] rd_byte;
   logic [7:0] wbyte;
   logic wr_ctrl, wr_cnt, wr_mod_hi, wr_mod_lo;

   logic ovf_flag_reg, ovf_ie_reg, center_aligned_pwm_reg;
   logic [1:0] clks_reg;
   logic [2:0] ps_reg;
   logic [6:0] presc_reg;
   logic [6:0] presc_mask;
   logic src_tick, tick, clks_off;

   logic [15:0] cnt_reg, cnt_next;
   dir_t dir_reg, dir_next;
   logic wrap, top_turn, free_run;
   logic [15:0] top_val;

   logic [15:0] mod_reg, mod_buf_reg;
   logic mod_hi_wr_reg, mod_lo_wr_reg, mod_load;

   logic [NUM_CH-1:0] ch_hit;
   logic [7:0] ch_rd [NUM_CH];

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wbyte = bus_in.hwdata[7:0];
   assign addr_ok = bus_in.haddr[31:8] == ADDR_UPPER_ZERO;
   assign wr_ctrl = dph_valid_reg && dph_write_reg && dph_addr_reg == ADDR_CTRL;
   assign wr_cnt = dph_valid_reg && dph_write_reg &&
      (dph_addr_reg == ADDR_CNT_HI || dph_addr_reg == ADDR_CNT_LO);
   assign wr_mod_hi = dph_valid_reg && dph_write_reg &&
      dph_addr_reg == ADDR_MOD_HI;
   assign wr_mod_lo = dph_valid_reg && dph_write_reg &&
      dph_addr_reg == ADDR_MOD_LO;

   // Address phase capture; writes land in the following data phase
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dph_valid_reg <= 1'b0;
         dph_write_reg <= 1'b0;
         dph_addr_reg <= BYTE_ZERO;
      end else if (bus_in.hready) begin
         dph_valid_reg <= bus_in.hsel && bus_in.htrans == HTRANS_NONSEQ &&
            addr_ok;
         dph_write_reg <= bus_in.hwrite;
         dph_addr_reg <= bus_in.haddr[7:0];
      end
   end

   // Read data is decoded in the address phase so the slave never waits
   always_comb begin
      rd_byte = BYTE_ZERO;
      if (bus_in.haddr[7:0] == ADDR_CTRL) begin
         rd_byte = {ovf_flag_reg, ovf_ie_reg, center_aligned_pwm_reg, clks_reg, ps_reg};
      end else if (bus_in.haddr[7:0] == ADDR_CNT_HI) begin
         rd_byte = cnt_reg[15:8];
      end else if (bus_in.haddr[7:0] == ADDR_CNT_LO) begin
         rd_byte = cnt_reg[7:0];
      end else if (bus_in.haddr[7:0] == ADDR_MOD_HI) begin
         rd_byte = mod_reg[15:8];
      end else if (bus_in.haddr[7:0] == ADDR_MOD_LO) begin
         rd_byte = mod_reg[7:0];
      end else if (|ch_hit) begin
         // At most one channel decodes an address, so the OR acts as a mux
         for (int k = 0; k < NUM_CH; k++) begin
            rd_byte = rd_byte | ch_rd[k];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hrdata <= WORD_ZERO;
      end else if (bus_in.hready && bus_in.hsel && !bus_in.hwrite &&
                   bus_in.htrans == HTRANS_NONSEQ) begin
         hrdata <= addr_ok ? {24'h000000, rd_byte} : WORD_ZERO;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ovf_ie_reg <= 1'b0;
         center_aligned_pwm_reg <= 1'b0;
         clks_reg <= CLKS_OFF;
         ps_reg <= 3'h0;
      end else if (wr_ctrl) begin
         ovf_ie_reg <= wbyte[CTRL_OVF_IE];
         center_aligned_pwm_reg <= wbyte[CTRL_CENTER_ALIGNED_PWM];
         clks_reg <= wbyte[CTRL_CLKS_LSB +: 2];
         ps_reg <= wbyte[CTRL_PS_LSB +: 3];
      end
   end

   // Prescaler divides the selected source by two to the power ps
   assign clks_off = clks_reg == CLKS_OFF;
   assign src_tick = clks_reg == CLKS_SYS ? 1'b1 : ext_clk_tick;
   assign presc_mask = ~(PRESC_ONES << ps_reg);
   assign tick = !clks_off && src_tick && !debug_halt_mode &&
      (presc_reg & presc_mask) == presc_mask;

   always_ff @(posedge sys_clk) begin
      if (rst || wr_cnt) begin
         presc_reg <= PRESC_ZERO;
      end else if (!clks_off && src_tick && !debug_halt_mode) begin
         presc_reg <= tick ? PRESC_ZERO : presc_reg + PRESC_ONE;
      end
   end

   assign free_run = mod_reg == CNT_ZERO || mod_reg == CNT_MAX;
   assign top_val = free_run ? CNT_MAX : mod_reg;

   always_comb begin
      cnt_next = cnt_reg;
      dir_next = dir_reg;
      wrap = 1'b0;
      top_turn = 1'b0;
      if (center_aligned_pwm_reg) begin
         if (dir_reg == DIR_UP) begin
            if (cnt_reg >= mod_reg) begin
               dir_next = DIR_DOWN;
               cnt_next = cnt_reg - CNT_ONE;
               top_turn = 1'b1;
            end else begin
               cnt_next = cnt_reg + CNT_ONE;
            end
         end else begin
            if (cnt_reg == CNT_ZERO) begin
               dir_next = DIR_UP;
               cnt_next = CNT_ONE;
            end else begin
               cnt_next = cnt_reg - CNT_ONE;
            end
         end
      end else begin
         if (cnt_reg >= top_val) begin
            cnt_next = CNT_ZERO;
            wrap = 1'b1;
         end else begin
            cnt_next = cnt_reg + CNT_ONE;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_reg <= CNT_ZERO;
         dir_reg <= DIR_UP;
      end else if (wr_cnt) begin
         cnt_reg <= CNT_ZERO;
         dir_reg <= DIR_UP;
      end else if (tick) begin
         cnt_reg <= cnt_next;
         dir_reg <= dir_next;
      end
   end

   // Set wins over a software clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ovf_flag_reg <= 1'b0;
      end else begin
         ovf_flag_reg <= (ovf_flag_reg && !(wr_ctrl && !wbyte[CTRL_OVF_FLAG]))
            || (tick && (wrap || top_turn));
      end
   end

   assign overflow_irq = ovf_flag_reg && ovf_ie_reg;

   assign mod_load = mod_hi_wr_reg && mod_lo_wr_reg &&
      (clks_off || (tick && (center_aligned_pwm_reg ? top_turn : wrap)));

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mod_buf_reg <= CNT_ZERO;
         mod_hi_wr_reg <= 1'b0;
         mod_lo_wr_reg <= 1'b0;
         mod_reg <= CNT_ZERO;
      end else begin
         if (mod_load) begin
            mod_reg <= mod_buf_reg;
         end
         mod_hi_wr_reg <= (mod_hi_wr_reg && !mod_load) || wr_mod_hi;
         mod_lo_wr_reg <= (mod_lo_wr_reg && !mod_load) || wr_mod_lo;
         if (wr_mod_hi) begin
            mod_buf_reg[15:8] <= wbyte;
         end
         if (wr_mod_lo) begin
            mod_buf_reg[7:0] <= wbyte;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         localparam logic [7:0] CH_ADDR =
            8'(ADDR_CH_BASE + 8'(gi) * ADDR_CH_STRIDE);
         ch_cfg_t cfg_reg;
         logic [15:0] val_reg, val_buf_reg;
         logic hi_wr_reg, lo_wr_reg, val_load, load_point;
         logic wr_cfg, wr_hi, wr_lo;
         logic is_oc, is_edge_aligned_pwm, match, zero_duty, full_duty;
         logic flag_set, pulse_next, out_next, out_reg;
         logic [7:0] addr_a;

         assign addr_a = bus_in.haddr[7:0];
         assign wr_cfg = dph_valid_reg && dph_write_reg &&
            dph_addr_reg == 8'(CH_ADDR + OFS_CH_CTRL);
         assign wr_hi = dph_valid_reg && dph_write_reg &&
            dph_addr_reg == 8'(CH_ADDR + OFS_CH_VAL_HI);
         assign wr_lo = dph_valid_reg && dph_write_reg &&
            dph_addr_reg == 8'(CH_ADDR + OFS_CH_VAL_LO);

         always_comb begin
            ch_hit[gi] = 1'b1;
            ch_rd[gi] = BYTE_ZERO;
            if (addr_a == 8'(CH_ADDR + OFS_CH_CTRL)) begin
               ch_rd[gi] = {cfg_reg, 2'b00};
            end else if (addr_a == 8'(CH_ADDR + OFS_CH_VAL_HI)) begin
               ch_rd[gi] = val_reg[15:8];
            end else if (addr_a == 8'(CH_ADDR + OFS_CH_VAL_LO)) begin
               ch_rd[gi] = val_reg[7:0];
            end else begin
               ch_hit[gi] = 1'b0;
            end
         end

         assign is_oc = !center_aligned_pwm_reg && cfg_reg.mode == MODE_OC;
         assign is_edge_aligned_pwm = !center_aligned_pwm_reg && cfg_reg.mode[1];

         always_comb begin
            if (center_aligned_pwm_reg) begin
               load_point = top_turn;
            end else if (is_edge_aligned_pwm) begin
               load_point = wrap;
            end else begin
               load_point = 1'b1;
            end
         end
         assign val_load = hi_wr_reg && lo_wr_reg &&
            (clks_off || (tick && load_point));

         always_ff @(posedge sys_clk) begin
            if (rst) begin
               val_buf_reg <= CNT_ZERO;
               val_reg <= CNT_ZERO;
               hi_wr_reg <= 1'b0;
               lo_wr_reg <= 1'b0;
            end else begin
               if (val_load) begin
                  val_reg <= val_buf_reg;
               end
               hi_wr_reg <= (hi_wr_reg && !val_load) || wr_hi;
               lo_wr_reg <= (lo_wr_reg && !val_load) || wr_lo;
               if (wr_hi) begin
                  val_buf_reg[15:8] <= wbyte;
               end
               if (wr_lo) begin
                  val_buf_reg[7:0] <= wbyte;
               end
            end
         end

         // Match is taken as the counter enters the channel value
         assign match = tick && cnt_next == val_reg;

         always_comb begin
            if (center_aligned_pwm_reg) begin
               zero_duty = val_reg == CNT_ZERO || val_reg[SIGN_BIT];
               full_duty = !val_reg[SIGN_BIT] && val_reg >= mod_reg &&
                  mod_reg != CNT_ZERO;
            end else begin
               zero_duty = val_reg == CNT_ZERO;
               full_duty = val_reg > mod_reg;
            end
         end

         assign flag_set = match && (center_aligned_pwm_reg || is_edge_aligned_pwm || is_oc) &&
            !((center_aligned_pwm_reg || is_edge_aligned_pwm) && (zero_duty || full_duty));

         // Pulse is the active phase; X:1 polarity inverts it at the pin
         always_comb begin
            pulse_next = out_reg ^ cfg_reg.els[0];
            if (center_aligned_pwm_reg) begin
               if (zero_duty) begin
                  pulse_next = 1'b0;
               end else if (full_duty) begin
                  pulse_next = 1'b1;
               end else if (match) begin
                  pulse_next = dir_next == DIR_DOWN;
               end
            end else if (is_edge_aligned_pwm) begin
               if (zero_duty) begin
                  pulse_next = 1'b0;
               end else if (full_duty) begin
                  pulse_next = 1'b1;
               end else if (match) begin
                  pulse_next = 1'b0;
               end else if (tick && wrap) begin
                  pulse_next = 1'b1;
               end
            end
            out_next = pulse_next ^ cfg_reg.els[0];
            if (is_oc) begin
               out_next = out_reg;
               if (match && cfg_reg.els == ELS_TOGGLE) begin
                  out_next = !out_reg;
               end else if (match && cfg_reg.els == ELS_CLEAR) begin
                  out_next = 1'b0;
               end else if (match && cfg_reg.els == ELS_SET) begin
                  out_next = 1'b1;
               end
            end
         end

         always_ff @(posedge sys_clk) begin
            if (rst) begin
               out_reg <= 1'b0;
            end else if (wr_cnt && !is_oc) begin
               out_reg <= cfg_reg.els[0];
            end else if (tick) begin
               out_reg <= out_next;
            end
         end

         always_ff @(posedge sys_clk) begin
            if (rst) begin
               cfg_reg <= '0;
            end else begin
               if (wr_cfg) begin
                  cfg_reg.ie <= wbyte[CH_IE];
                  cfg_reg.mode <= wbyte[CH_MODE_LSB +: 2];
                  cfg_reg.els <= wbyte[CH_ELS_LSB +: 2];
               end
               cfg_reg.flag <= (cfg_reg.flag && !(wr_cfg && !wbyte[CH_FLAG]))
                  || flag_set;
            end
         end

         assign ch_out[gi] = out_reg;
         assign ch_oe[gi] = cfg_reg.els != ELS_NONE &&
            (center_aligned_pwm_reg || is_edge_aligned_pwm || is_oc);
         assign channel_irq[gi] = cfg_reg.flag && cfg_reg.ie;
      end
   endgenerate

endmodule

// *** center_pwm_timer_chk.sv ***
// Port-level concurrent checks for the center-aligned PWM timer
`timescale 1ns/1ps
module center_pwm_timer_chk (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire center_pwm_pkg::ahb_in_t bus_in, // Bus request
   input wire logic hreadyout, // Slave ready
   input wire logic hresp, // Slave response
   input wire logic [31:0] hrdata, // Read data
   input wire logic ext_clk_tick, // External tick
   input wire logic debug_halt_mode, // Debug halt
   input wire logic [center_pwm_pkg::NUM_CH-1:0] ch_out, // Pin levels
   input wire logic [center_pwm_pkg::NUM_CH-1:0] ch_oe, // Pin enables
   input wire logic overflow_irq, // Overflow request
   input wire logic [center_pwm_pkg::NUM_CH-1:0] channel_irq // Requests
);
   import center_pwm_pkg::*;
   logic wr_dp_reg;
   logic [7:0] wr_addr_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] chc_reg [NUM_CH];
   logic cnt_dp;
   logic [NUM_CH-1:0] non_oc;
   logic [NUM_CH-1:0] init_lvl;
   logic [NUM_CH-1:0] els_on;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Writes land at the end of the data phase, so remember the address
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_dp_reg <= 1'b0;
         wr_addr_reg <= BYTE_ZERO;
      end else begin
         wr_dp_reg <= bus_in.hsel && bus_in.hready && bus_in.hwrite &&
            bus_in.htrans == HTRANS_NONSEQ &&
            bus_in.haddr[31:8] == ADDR_UPPER_ZERO;
         wr_addr_reg <= bus_in.haddr[7:0];
      end
   end
   // Shadow of the control bytes that decide pin enables and levels
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_reg <= BYTE_ZERO;
         chc_reg <= '{default: BYTE_ZERO};
      end else if (wr_dp_reg) begin
         if (wr_addr_reg == ADDR_CTRL) ctrl_reg <= bus_in.hwdata[7:0];
         for (int i = 0; i < NUM_CH; i++) begin
            if (wr_addr_reg == ADDR_CH_BASE + 8'(i) * ADDR_CH_STRIDE)
               chc_reg[i] <= bus_in.hwdata[7:0];
         end
      end
   end
   always_comb begin
      cnt_dp = wr_dp_reg &&
         (wr_addr_reg == ADDR_CNT_HI || wr_addr_reg == ADDR_CNT_LO);
      for (int i = 0; i < NUM_CH; i++) begin
         non_oc[i] = ctrl_reg[CTRL_CENTER_ALIGNED_PWM] || chc_reg[i][CH_MODE_LSB+1];
         init_lvl[i] = chc_reg[i][CH_ELS_LSB];
         els_on[i] = chc_reg[i][CH_ELS_LSB+1:CH_ELS_LSB] != ELS_NONE;
      end
   end
   chk_reset_quiet: assert property ($fell(rst) |-> ch_out == '0 &&
      ch_oe == '0 && !overflow_irq && channel_irq == '0 && hrdata == '0)
      else $error("outputs not quiet after reset");
   chk_halt_freeze: assert property (debug_halt_mode && !wr_dp_reg
      |=> $stable(ch_out)) else $error("pin moved during halt");
   chk_halt_no_event: assert property (debug_halt_mode && !wr_dp_reg
      |=> !$rose(overflow_irq) && (channel_irq & ~$past(channel_irq)) == '0)
      else $error("event raised during halt");
   chk_oe_static: assert property (!wr_dp_reg |=> $stable(ch_oe))
      else $error("pin enable changed without a write");
   chk_oe_none: assert property ((ch_oe & ~els_on) == '0)
      else $error("pin driven with edge level select zero");
   chk_cnt_init: assert property (cnt_dp |=>
      ((ch_out ^ $past(init_lvl)) & $past(non_oc)) == '0)
      else $error("pin not at initial level after counter write");
   chk_ovf_irq_hold: assert property (overflow_irq && !wr_dp_reg
      |=> overflow_irq) else $error("overflow request dropped");
   chk_ch_irq_hold: assert property (!wr_dp_reg |=>
      (channel_irq & $past(channel_irq)) == $past(channel_irq))
      else $error("channel request dropped");
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
endmodule

bind center_pwm_timer center_pwm_timer_chk u_center_pwm_timer_chk (
   .sys_clk, .rst, .bus_in, .hreadyout, .hresp, .hrdata, .ext_clk_tick,
   .debug_halt_mode, .ch_out, .ch_oe, .overflow_irq, .channel_irq);

// *** tb.sv ***
// Self-checking bench for the center-aligned PWM timer
`timescale 1ns/1ps
module tb;
   import center_pwm_pkg::*;
   logic sys_clk;
   logic rst;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [31:0] hwdata;
   logic ext_clk_tick;
   logic debug_halt_mode;
   ahb_in_t bus_in;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [NUM_CH-1:0] ch_out;
   logic [NUM_CH-1:0] ch_oe;
   logic overflow_irq;
   logic [NUM_CH-1:0] channel_irq;
   logic [31:0] rd;
   logic [31:0] snap;
   int err_count;
   int comparisons;
   int ones;
   int rises;
   logic [15:0] vals [4] = '{16'h0003, 16'h0000, 16'h8005, 16'h0004};
   int exp_ones [4] = '{48, 0, 0, 64};
   logic [3:0] exp_irq = 4'b0001;
   // Word transfers only; single slave so hready is its own ready
   assign bus_in = '{hsel, haddr, htrans, hwrite, 3'h2, hreadyout, hwdata};
   center_pwm_timer u_center_pwm_timer (.sys_clk, .rst, .bus_in, .hreadyout,
      .hresp, .hrdata, .ext_clk_tick, .debug_halt_mode, .ch_out, .ch_oe,
      .overflow_irq, .channel_irq);
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [7:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {ADDR_UPPER_ZERO, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d, rd);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, BYTE_ZERO, rd);
      check(rd, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Counts high cycles and rising edges of one pin over n cycles
   task automatic measure(input int ch, input int n);
      logic prev;
      ones = 0;
      rises = 0;
      @(posedge sys_clk);
      #1 prev = ch_out[ch];
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         ones += int'(ch_out[ch] === 1'b1);
         rises += int'(ch_out[ch] === 1'b1 && prev === 1'b0);
         prev = ch_out[ch];
      end
   endtask
   task automatic final_report;
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      final_report;
   end
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = WORD_ZERO;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = WORD_ZERO;
      ext_clk_tick = 1'b0;
      debug_halt_mode = 1'b0;
      err_count = 0;
      comparisons = 0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      check(32'({ch_out, ch_oe, channel_irq, overflow_irq}), WORD_ZERO);
      for (int a = 0; a <= 'h28; a += 4) rd_chk(8'(a), WORD_ZERO);
      wr(8'h80, 8'hFF);
      rd_chk(8'h80, WORD_ZERO);
      wr(ADDR_MOD_LO, 8'h08);
      idle(2);
      rd_chk(ADDR_MOD_LO, WORD_ZERO);
      wr(ADDR_MOD_HI, 8'h00);
      idle(2);
      rd_chk(ADDR_MOD_LO, 32'h08);
      wr(8'h18, 8'h00);
      wr(8'h1C, 8'h03);
      wr(8'h24, 8'h00);
      wr(8'h28, 8'h02);
      idle(2);
      rd_chk(8'h1C, 32'h03);
      wr(8'h14, 8'h68);
      wr(8'h20, 8'h64);
      wr(ADDR_CTRL, 8'h68);
      // First up-count from zero has no pulse yet; measure in steady state
      idle(16);
      measure(0, 64);
      check(ones, 24);
      check(rises, 4);
      measure(1, 64);
      check(ones, 48);
      check(32'(overflow_irq), 32'h1);
      check(32'(channel_irq), 32'h3);
      wr(ADDR_CTRL, 8'h28);
      idle(1);
      check(32'(overflow_irq), 32'h0);
      idle(20);
      rd_chk(ADDR_CTRL, 32'hA8);
      wr(8'h14, 8'h28);
      idle(1);
      check(32'(channel_irq[0]), 32'h0);
      wr(8'h20, 8'h60);
      idle(20);
      check(32'(ch_oe), 32'h1);
      check(32'(channel_irq), 32'h2);
      wr(8'h20, 8'h64);
      debug_halt_mode <= 1'b1;
      idle(2);
      bus(1'b0, ADDR_CNT_LO, BYTE_ZERO, snap);
      #1 rd = 32'(ch_out);
      idle(10);
      check(32'(ch_out), rd);
      rd_chk(ADDR_CNT_LO, snap);
      wr(ADDR_CNT_HI, 8'h55);
      rd_chk(ADDR_CNT_LO, WORD_ZERO);
      check(32'(ch_out), 32'h2);
      // Loads are staged while halted so no load point can slip in early
      wr(ADDR_MOD_HI, 8'h00);
      wr(ADDR_MOD_LO, 8'h04);
      idle(4);
      rd_chk(ADDR_MOD_LO, 32'h08);
      debug_halt_mode <= 1'b0;
      idle(20);
      rd_chk(ADDR_MOD_LO, 32'h04);
      for (int k = 0; k < 4; k++) begin
         wr(8'h18, vals[k][15:8]);
         wr(8'h1C, vals[k][7:0]);
         idle(20);
         wr(8'h14, 8'h68);
         measure(0, 64);
         check(ones, exp_ones[k]);
         check(32'(channel_irq[0]), 32'(exp_irq[k]));
      end
      // Up counting: new modulo and edge-aligned value wait for the wrap
      wr(ADDR_CTRL, 8'h08);
      wr(ADDR_MOD_HI, 8'h00);
      wr(ADDR_MOD_LO, 8'h09);
      wr(8'h18, 8'h00);
      wr(8'h1C, 8'h02);
      rd_chk(8'h1C, 32'h04);
      idle(12);
      rd_chk(ADDR_MOD_LO, 32'h09);
      rd_chk(8'h1C, 32'h02);
      measure(0, 60);
      check(ones, 12);
      // External pulses are the only count source; compare value waits
      wr(ADDR_CTRL, 8'h10);
      wr(8'h20, 8'h50);
      wr(8'h24, 8'h00);
      wr(8'h28, 8'h05);
      rd_chk(8'h28, 32'h02);
      wr(ADDR_CNT_LO, 8'h00);
      repeat (3) begin
         ext_clk_tick <= 1'b1;
         @(posedge sys_clk);
         ext_clk_tick <= 1'b0;
         @(posedge sys_clk);
      end
      rd_chk(ADDR_CNT_LO, 32'h03);
      rd_chk(8'h28, 32'h05);
      // Prescale by two: one count every second cycle
      wr(ADDR_CTRL, 8'h09);
      wr(ADDR_CNT_LO, 8'h00);
      idle(8);
      rd_chk(ADDR_CNT_LO, 32'h04);
      final_report;
   end
endmodule
